// *** core/synth_regs_pkg.sv ***
package synth_regs_pkg;

  // ==========================================================
  // bus and storage geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;
  localparam int NUM_RW = 9;
  localparam int NUM_SLOTS = 10;
  localparam int EFF_W  = 8;

  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_PUMP_CFG    = 6'h0e;
  localparam logic [5:0] IDX_RSV_A       = 6'h13;
  localparam logic [5:0] IDX_RSV_B       = 6'h17;
  localparam logic [5:0] IDX_RSV_C       = 6'h18;
  localparam logic [5:0] IDX_RSV_D       = 6'h1c;
  localparam logic [5:0] IDX_RSV_E       = 6'h1d;
  localparam logic [5:0] IDX_DITHER_DBL  = 6'h1e;
  localparam logic [5:0] IDX_DIST_PWR    = 6'h1f;
  localparam logic [5:0] IDX_RSV_F       = 6'h20;
  localparam logic [5:0] IDX_PUMP_STATUS = 6'h3f;

  // slot numbers inside the storage array
  localparam logic [3:0] SLOT_PUMP   = 4'h0;
  localparam logic [3:0] SLOT_DITHER = 4'h6;
  localparam logic [3:0] SLOT_DIST   = 4'h7;
  localparam logic [3:0] SLOT_STATUS = 4'h9;
  localparam logic [3:0] SLOT_NONE   = 4'hf;

  localparam logic [5:0] SLOT_IDX [NUM_SLOTS] = '{
    IDX_PUMP_CFG, IDX_RSV_A, IDX_RSV_B, IDX_RSV_C, IDX_RSV_D,
    IDX_RSV_E, IDX_DITHER_DBL, IDX_DIST_PWR, IDX_RSV_F, IDX_PUMP_STATUS};

  // ==========================================================
  // values after reset
  localparam logic [REG_W-1:0] PUMP_CFG_RST   = 16'h018d;
  localparam logic [REG_W-1:0] DITHER_DBL_RST = 16'h0000;
  localparam logic [REG_W-1:0] DIST_PWR_RST   = 16'h0400;
  localparam logic [REG_W-1:0] RSV_RST        = 16'h0000;
  localparam logic [EFF_W-1:0] EFF_RST        = 8'h0c;

  localparam logic [REG_W-1:0] RESET_VAL [NUM_RW] = '{
    PUMP_CFG_RST, RSV_RST, RSV_RST, RSV_RST, RSV_RST,
    RSV_RST, DITHER_DBL_RST, DIST_PWR_RST, RSV_RST};

  // ==========================================================
  // field positions
  localparam int PUMP_DN_MSB = 11;
  localparam int PUMP_DN_LSB = 7;
  localparam int PUMP_UP_MSB = 6;
  localparam int PUMP_UP_LSB = 2;
  localparam int GAIN_MSB    = 1;
  localparam int GAIN_LSB    = 0;
  localparam int DITHER_BIT  = 10;
  localparam int DOUBLER_BIT = 0;
  localparam int OUT_B_PD_BIT = 10;
  localparam int OUT_A_PD_BIT = 9;
  localparam int DIV_FEED_PD_BIT = 7;

  // ==========================================================
  // pump current weights in steps of 0.15625 ma per set bit
  localparam logic [4:0] CUR_WEIGHT [5] = '{5'h01, 5'h02, 5'h04, 5'h10, 5'h08};
  // gain factor times two, indexed by multiplier code
  localparam logic [EFF_W-1:0] GAIN_X2 [4] = '{8'h02, 8'h04, 8'h03, 8'h05};

  function automatic logic [4:0] pump_units(input logic [4:0] f);
    logic [4:0] s;
    s = 5'h00;
    for (int i = 0; i < 5; i++) begin
      if (f[i]) begin
        s = s + CUR_WEIGHT[i];
      end
    end
    return s;
  endfunction

  // result in steps of 0.078125 ma
  function automatic logic [EFF_W-1:0] pump_eff(input logic [4:0] f,
                                                input logic [1:0] g);
    return EFF_W'({3'h0, pump_units(f)} * GAIN_X2[g]);
  endfunction

  // ==========================================================
  // carriers
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [3:0]        pstrb;
  } apb_req_type;

  typedef struct packed {
    logic [4:0] pump_down_current;
    logic [4:0] pump_up_current;
    logic [1:0] pump_gain_multiplier;
    logic       modulator_dither_enable;
    logic       oscillator_doubler_enable;
    logic       output_b_buffer_powerdown;
    logic       output_a_buffer_powerdown;
    logic       divider_feed_buffer_powerdown;
  } synth_ctrl_type;

endpackage

// *** core/pump_current_calc.sv ***
`timescale 1ns/1ps
`default_nettype none

module pump_current_calc (
  input  wire logic                          sys_clk_i,
  input  wire logic                          reset_n_i,
  input  wire logic [4:0]                    current_i,
  input  wire logic [1:0]                    gain_i,
  output logic [synth_regs_pkg::EFF_W-1:0]   eff_o
);
  import synth_regs_pkg::*;

  // ==========================================================
  // registered so the product never reaches a port as a ripple
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      eff_o <= EFF_RST;
    end else begin
      eff_o <= pump_eff(current_i, gain_i);
    end
  end

endmodule

`default_nettype wire

// *** core/synth_pump_dist_regs.sv ***
// Behaviour
// - pump-down current in bits 11:7, reset 3, weights 1.25/2.5/0.625/0.312/0.156 ma
// - pump-up current in bits 6:2, reset 3, same weights, any bit mix
// - gain code bits 1:0, reset 1: 3 x2.5, 2 x1.5, 1 x2, 0 x1
// - bit 10 of dither register, reset 0, turns modulator dither on
// - bit 0 of dither register, reset 0, enables oscillator doubler
// - distribution bit 10, reset 1, powers down output b buffer
// - distribution bit 9, reset 0, powers down output a buffer
// - distribution bit 7, reset 0, powers down divider feed buffer
`timescale 1ns/1ps
`default_nettype none

module synth_pump_dist_regs (
  input  wire logic                           sys_clk_i,
  input  wire logic                           reset_n_i,
  input  wire synth_regs_pkg::apb_req_type    apb_i,
  output logic [synth_regs_pkg::DATA_W-1:0]   prdata_o,
  output logic                                pready_o,
  output logic                                pslverr_o,
  output var synth_regs_pkg::synth_ctrl_type  ctrl_o,
  output logic [synth_regs_pkg::EFF_W-1:0]    pump_down_eff_o,
  output logic [synth_regs_pkg::EFF_W-1:0]    pump_up_eff_o,
  output logic                                pump_mismatch_o
);
  import synth_regs_pkg::*;

  // ==========================================================
  // address decode
  function automatic logic [3:0] find_slot(input logic [ADDR_W-1:0] a);
    logic [3:0] s;
    s = SLOT_NONE;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (a[1:0] == 2'h0 && a[ADDR_W-1:2] == SLOT_IDX[i]) begin
        s = 4'(i);
      end
    end
    return s;
  endfunction

  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
                                             input logic [DATA_W-1:0] wd,
                                             input logic [3:0] strb);
    logic [REG_W-1:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  logic [REG_W-1:0] regs_r [NUM_RW];
  logic [3:0]       slot;
  logic             access_first;
  logic             wr_fire;
  logic [DATA_W-1:0] rd_mux;
  logic [4:0]       cur_field [2];
  logic [EFF_W-1:0] eff_w [2];

  assign slot = find_slot(apb_i.paddr);
  // first access cycle; the answer follows one cycle later
  assign access_first = apb_i.psel && apb_i.penable && !pready_o;
  assign wr_fire = apb_i.psel && apb_i.penable && pready_o && apb_i.pwrite;

  // ==========================================================
  // apb handshake
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= access_first;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pslverr_o <= 1'b0;
    end else begin
      pslverr_o <= access_first && (slot == SLOT_NONE);
    end
  end

  always_comb begin
    rd_mux = '0;
    if (slot == SLOT_STATUS) begin
      rd_mux = {15'h0000, pump_mismatch_o, pump_up_eff_o, pump_down_eff_o};
    end else if (slot != SLOT_NONE) begin
      rd_mux = {16'h0000, regs_r[slot]};
    end
  end

  // read data is latched on the same edge that raises pready so it is stable when sampled
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_o <= '0;
    end else if (access_first && !apb_i.pwrite) begin
      prdata_o <= rd_mux;
    end
  end

  // ==========================================================
  // storage; unnamed bits are kept as written, no masking
  for (genvar g = 0; g < NUM_RW; g++) begin : g_store
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        regs_r[g] <= RESET_VAL[g];
      end else if (wr_fire && slot == 4'(g)) begin
        regs_r[g] <= merge(regs_r[g], apb_i.pwdata, apb_i.pstrb);
      end
    end
  end

  // ==========================================================
  // control fields toward the analog side
  assign ctrl_o.pump_down_current =
    regs_r[SLOT_PUMP][PUMP_DN_MSB:PUMP_DN_LSB];
  assign ctrl_o.pump_up_current =
    regs_r[SLOT_PUMP][PUMP_UP_MSB:PUMP_UP_LSB];
  assign ctrl_o.pump_gain_multiplier =
    regs_r[SLOT_PUMP][GAIN_MSB:GAIN_LSB];
  assign ctrl_o.modulator_dither_enable =
    regs_r[SLOT_DITHER][DITHER_BIT];
  assign ctrl_o.oscillator_doubler_enable =
    regs_r[SLOT_DITHER][DOUBLER_BIT];
  assign ctrl_o.output_b_buffer_powerdown =
    regs_r[SLOT_DIST][OUT_B_PD_BIT];
  assign ctrl_o.output_a_buffer_powerdown =
    regs_r[SLOT_DIST][OUT_A_PD_BIT];
  assign ctrl_o.divider_feed_buffer_powerdown =
    regs_r[SLOT_DIST][DIV_FEED_PD_BIT];

  // ==========================================================
  // effective pump current, one calculator per direction
  assign cur_field[0] = ctrl_o.pump_down_current;
  assign cur_field[1] = ctrl_o.pump_up_current;

  for (genvar d = 0; d < 2; d++) begin : g_calc
    pump_current_calc u_calc (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .current_i (cur_field[d]),
      .gain_i    (ctrl_o.pump_gain_multiplier),
      .eff_o     (eff_w[d])
    );
  end

  assign pump_down_eff_o = eff_w[0];
  assign pump_up_eff_o   = eff_w[1];

  // ==========================================================
  // mismatch is only flagged; hardware does not force equality
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pump_mismatch_o <= 1'b0;
    end else begin
      pump_mismatch_o <= (ctrl_o.pump_down_current != ctrl_o.pump_up_current);
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  logic wr_pump_full;
  logic wr_pump_any;
  logic wr_pump_lo;
  logic wr_dith_lo;
  logic wr_dith_hi;
  logic wr_dist_lo;
  logic wr_dist_hi;

  assign wr_pump_any  = wr_fire && slot == SLOT_PUMP;
  assign wr_pump_full = wr_pump_any && apb_i.pstrb[1:0] == 2'h3;
  assign wr_pump_lo   = wr_pump_any && apb_i.pstrb[0];
  assign wr_dith_lo   = wr_fire && slot == SLOT_DITHER && apb_i.pstrb[0];
  assign wr_dith_hi   = wr_fire && slot == SLOT_DITHER && apb_i.pstrb[1];
  assign wr_dist_lo   = wr_fire && slot == SLOT_DIST && apb_i.pstrb[0];
  assign wr_dist_hi   = wr_fire && slot == SLOT_DIST && apb_i.pstrb[1];

  a_pump_dn_write: assert property (
    wr_pump_full |=> ctrl_o.pump_down_current ==
      $past(apb_i.pwdata[PUMP_DN_MSB:PUMP_DN_LSB]))
    else $error("pump-down field not written");

  a_pump_dn_hold: assert property (
    !wr_pump_any |=> $stable(ctrl_o.pump_down_current))
    else $error("pump-down field changed without write");

  a_pump_up_write: assert property (
    wr_pump_lo |=> ctrl_o.pump_up_current ==
      $past(apb_i.pwdata[PUMP_UP_MSB:PUMP_UP_LSB]))
    else $error("pump-up field not written");

  a_gain_code_write: assert property (
    wr_pump_lo |=> ctrl_o.pump_gain_multiplier ==
      $past(apb_i.pwdata[GAIN_MSB:GAIN_LSB]))
    else $error("gain field not written");

  a_dither_enable: assert property (
    wr_dith_hi |=> ctrl_o.modulator_dither_enable ==
      $past(apb_i.pwdata[DITHER_BIT]))
    else $error("dither bit not written");

  a_doubler_enable: assert property (
    $changed(ctrl_o.oscillator_doubler_enable) |-> $past(wr_dith_lo))
    else $error("doubler changed without write");

  a_out_b_pd: assert property (
    wr_dist_hi ##1 1'b1 |-> ctrl_o.output_b_buffer_powerdown ==
      $past(apb_i.pwdata[OUT_B_PD_BIT]))
    else $error("output b power-down not written");

  a_out_a_pd: assert property (
    wr_dist_hi |=> ctrl_o.output_a_buffer_powerdown ==
      $past(apb_i.pwdata[OUT_A_PD_BIT]))
    else $error("output a power-down not written");

  a_div_feed_pd: assert property (
    wr_dist_lo |=> ctrl_o.divider_feed_buffer_powerdown ==
      $past(apb_i.pwdata[DIV_FEED_PD_BIT]))
    else $error("divider feed power-down not written");

  a_eff_current: assert property (
    wr_pump_full |=> ##1 pump_down_eff_o ==
      pump_eff($past(apb_i.pwdata[PUMP_DN_MSB:PUMP_DN_LSB], 2),
               $past(apb_i.pwdata[GAIN_MSB:GAIN_LSB], 2)))
    else $error("effective current mismatch");

  a_ready_pulse: assert property (
    access_first |=> pready_o ##1 !pready_o)
    else $error("pready not a single pulse");

  a_err_unmapped: assert property (
    pslverr_o |-> pready_o && $past(slot) == SLOT_NONE)
    else $error("slave error without unmapped access");

  a_pump_up_hold: assert property (
    !wr_pump_lo |=> $stable(ctrl_o.pump_up_current))
    else $error("pump-up field changed without write");

  a_gain_code_hold: assert property (
    !wr_pump_lo |=> $stable(ctrl_o.pump_gain_multiplier))
    else $error("gain field changed without write");

  a_dither_hold: assert property (
    !wr_dith_hi |=> $stable(ctrl_o.modulator_dither_enable))
    else $error("dither bit changed without write");

  a_doubler_write: assert property (
    wr_dith_lo |=> ctrl_o.oscillator_doubler_enable ==
      $past(apb_i.pwdata[DOUBLER_BIT]))
    else $error("doubler bit not written");

  a_out_b_hold: assert property (
    !wr_dist_hi |=> $stable(ctrl_o.output_b_buffer_powerdown))
    else $error("output b power-down changed without write");

  a_out_a_hold: assert property (
    !wr_dist_hi |=> $stable(ctrl_o.output_a_buffer_powerdown))
    else $error("output a power-down changed without write");

  a_div_feed_hold: assert property (
    !wr_dist_lo |=> $stable(ctrl_o.divider_feed_buffer_powerdown))
    else $error("divider feed power-down changed without write");

  a_mismatch_flag: assert property (
    1'b1 |=> pump_mismatch_o ==
      $past(ctrl_o.pump_down_current != ctrl_o.pump_up_current))
    else $error("mismatch flag does not follow the fields");

  a_eff_equal_fields: assert property (
    $past(ctrl_o.pump_down_current) == $past(ctrl_o.pump_up_current) |->
      pump_down_eff_o == pump_up_eff_o)
    else $error("equal fields give unequal effective currents");

  a_status_wr_ignored: assert property (
    wr_fire && slot == SLOT_STATUS |=> $stable(ctrl_o))
    else $error("status write changed a control field");

  a_unmapped_wr: assert property (
    wr_fire && slot == SLOT_NONE |=> $stable(ctrl_o))
    else $error("unmapped write changed a control field");

  a_err_pulse: assert property (
    pslverr_o |=> !pslverr_o)
    else $error("slave error longer than one cycle");

  a_rdata_hold: assert property (
    !(access_first && !apb_i.pwrite) |=> $stable(prdata_o))
    else $error("read data changed without a read");

  a_ready_idle: assert property (
    !(apb_i.psel && apb_i.penable) |=> !pready_o)
    else $error("pready without an access phase");

  c_pump_write: cover property (wr_pump_full ##2 pump_mismatch_o);
  c_status_read: cover property (
    access_first && !apb_i.pwrite && slot == SLOT_STATUS ##1 pready_o);
  c_unmapped: cover property (pslverr_o);
  c_out_b_up: cover property ($fell(ctrl_o.output_b_buffer_powerdown));

endmodule

`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import synth_regs_pkg::*;

  // ==========================================================
  // stimulus, design and scoreboard
  typedef struct packed {logic chk; logic [31:0] d; logic e;} note_type;

  logic                      sys_clk_i = 1'b0;
  logic                      reset_n_i = 1'b0;
  apb_req_type               apb_i     = '0;
  logic [DATA_W-1:0]         prdata_o;
  logic                      pready_o;
  logic                      pslverr_o;
  synth_ctrl_type            ctrl_o;
  logic [EFF_W-1:0]          pump_down_eff_o;
  logic [EFF_W-1:0]          pump_up_eff_o;
  logic                      pump_mismatch_o;
  note_type                  notes[$];
  note_type                  nt;
  int                        n_mismatch  = 0;
  int                        comparisons = 0;
  logic [15:0]               sh [64];
  logic [31:0]               lfsr = 32'h1b67;
  logic [31:0]               v;

  always #5 sys_clk_i = ~sys_clk_i;

  synth_pump_dist_regs synth_pump_dist_regs_inst (
    .sys_clk_i       (sys_clk_i),
    .reset_n_i       (reset_n_i),
    .apb_i           (apb_i),
    .prdata_o        (prdata_o),
    .pready_o        (pready_o),
    .pslverr_o       (pslverr_o),
    .ctrl_o          (ctrl_o),
    .pump_down_eff_o (pump_down_eff_o),
    .pump_up_eff_o   (pump_up_eff_o),
    .pump_mismatch_o (pump_mismatch_o)
  );

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h0);
    return lfsr;
  endfunction

  // effective current in 0.078125 ma steps; weights 0.156/0.312/0.625/2.5/1.25 ma
  function automatic logic [7:0] eff(input logic [4:0] f, input logic [1:0] g);
    logic [7:0] u;
    u = 8'(f[0]) * 2 + 8'(f[1]) * 4 + 8'(f[2]) * 8 + 8'(f[3]) * 32 + 8'(f[4]) * 16;
    case (g)
      2'd0: return u;
      2'd1: return u * 2;
      2'd2: return u + u / 2;
      default: return u * 2 + u / 2;
    endcase
  endfunction

  function automatic logic [31:0] stat();
    logic [15:0] p;
    p = sh[IDX_PUMP_CFG];
    return {15'h0, p[11:7] != p[6:2], eff(p[6:2], p[1:0]), eff(p[11:7], p[1:0])};
  endfunction

  function automatic synth_ctrl_type exp_ctrl();
    return '{sh[IDX_PUMP_CFG][11:7], sh[IDX_PUMP_CFG][6:2], sh[IDX_PUMP_CFG][1:0],
             sh[IDX_DITHER_DBL][10], sh[IDX_DITHER_DBL][0], sh[IDX_DIST_PWR][10],
             sh[IDX_DIST_PWR][9], sh[IDX_DIST_PWR][7]};
  endfunction

  task automatic init_sh();
    foreach (sh[i]) sh[i] = 16'h0000;
    sh[IDX_PUMP_CFG] = {4'h0, 5'd3, 5'd3, 2'd1};
    sh[IDX_DIST_PWR] = 16'h0400;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ==========================================================
  // apb master; the answer is judged by the monitor below
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic chk, input logic [31:0] ed,
                     input logic ee);
    notes.push_back('{chk, ed, ee});
    @(posedge sys_clk_i);
    apb_i <= '{1'b1, 1'b0, wr, a, d, s};
    @(posedge sys_clk_i);
    apb_i.penable <= 1'b1;
    @(posedge sys_clk_i);
    // no cycle count assumed; the watchdog ends a hung wait
    while (pready_o !== 1'b1) begin
      @(posedge sys_clk_i);
    end
    apb_i <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic ee);
    apb(1'b1, a, d, s, 1'b0, 32'h0, ee);
    if (!ee && a != 8'hfc) begin
      if (s[0]) sh[a[7:2]][7:0] = d[7:0];
      if (s[1]) sh[a[7:2]][15:8] = d[15:8];
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic ee);
    apb(1'b0, a, 32'h0, 4'h0, 1'b1, ee ? 32'h0 : (a == 8'hfc ? stat() : {16'h0, sh[a[7:2]]}), ee);
  endtask

  task automatic check_outs();
    @(posedge sys_clk_i);
    #1;
    check(32'(ctrl_o), 32'(exp_ctrl()));
    check({15'h0, pump_mismatch_o, pump_up_eff_o, pump_down_eff_o}, stat());
  endtask

  task automatic read_all();
    for (int i = 0; i < NUM_RW; i++) rd({SLOT_IDX[i], 2'b00}, 1'b0);
    rd(8'hfc, 1'b0);
  endtask

  always @(posedge sys_clk_i) begin
    if (reset_n_i === 1'b1 && pready_o === 1'b1) begin
      if (notes.size() == 0) begin
        check({31'h0, pready_o}, 32'h0);
      end else begin
        nt = notes.pop_front();
        check({31'h0, pslverr_o}, {31'h0, nt.e});
        if (nt.chk) check(prdata_o, nt.d);
      end
    end
  end

  task automatic report_and_stop();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_mismatch++;
    report_and_stop();
  end

  // ==========================================================
  // scenarios
  initial begin
    init_sh();
    repeat (20) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    check_outs();
    read_all();
    rd(8'h00, 1'b1);
    rd(8'h39, 1'b1);
    // reserved words are plain storage; up and down fields kept equal
    for (int i = 0; i < NUM_RW; i++) begin
      v = rnd();
      if (i == 0) v[11:7] = v[6:2];
      wr({SLOT_IDX[i], 2'b00}, v, 4'hf, 1'b0);
    end
    check_outs();
    read_all();
    // every gain code, with the all-ones field as the top boundary
    for (int k = 0; k < 8; k++) begin
      v = rnd();
      if (k == 7) v[6:2] = 5'h1f;
      v[11:7] = v[6:2];
      v[1:0] = k[1:0];
      wr(8'h38, v, 4'h3, 1'b0);
      check_outs();
      rd(8'hfc, 1'b0);
    end
    // unequal fields flag a mismatch but are still stored
    wr(8'h38, 32'h0000_0f8c, 4'h3, 1'b0);
    check_outs();
    rd(8'hfc, 1'b0);
    // byte lanes, status writes and unmapped writes
    wr(8'h7c, 32'hffff_ffff, 4'h1, 1'b0);
    wr(8'h78, 32'h0000_0401, 4'h2, 1'b0);
    wr(8'h78, {31'h0, ~sh[IDX_DITHER_DBL][0]}, 4'h1, 1'b0);
    check_outs();
    wr(8'hfc, 32'hffff_ffff, 4'hf, 1'b0);
    wr(8'h04, 32'hffff_ffff, 4'hf, 1'b1);
    wr(8'h7e, 32'h0000_0000, 4'hf, 1'b1);
    read_all();
    check_outs();
    // reset in mid-run brings every default back
    @(posedge sys_clk_i);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    init_sh();
    check_outs();
    read_all();
    report_and_stop();
  end

endmodule

`default_nettype wire
